// *** src/msd_pkg.sv ***
// Constants, mode codes and cycle counts for the memory space decoder.
// Assumes a single core clock; no registers reachable by software.
package msd_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [7:0] MSD_UPPER_BASE = 8'h80; // Upper half: SPECIAL_FUNCTION_REGISTER_SPACE or upper RAM
  localparam logic [7:0] MSD_BIT_BASE = 8'h20; // First bit-addressable RAM byte
  localparam logic [7:0] MSD_BANK_TOP = 8'h1F; // Last byte of the register banks
  localparam logic [7:0] MSD_SFR_SP = 8'h81; // Stack pointer
  localparam logic [7:0] MSD_SFR_DPL = 8'h82; // Data pointer low byte
  localparam logic [7:0] MSD_SFR_DPH = 8'h83; // Data pointer high byte
  localparam logic [7:0] MSD_SFR_PSW = 8'hD0; // Program status word
  localparam int MSD_BANK_LSB = 3; // Bank select low bit in the status word
  localparam int MSD_BANK_MSB = 4; // Bank select high bit in the status word

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MSD_SP_RST = 8'h00; // Stack pointer after reset
  localparam logic [7:0] MSD_DP_RST = 8'h00; // Data pointer bytes after reset
  localparam logic [7:0] MSD_PSW_RST = 8'h00; // Status word after reset

  // ----------------------------------------------------------------
  // Cycle counts per addressing mode
  // ----------------------------------------------------------------
  localparam logic [1:0] MSD_CYC_REG = 2'h1; // Working register move
  localparam logic [1:0] MSD_CYC_TWO = 2'h2; // Direct, indirect, immediate, bit, stack
  localparam logic [2:0] MSD_CYC_JMP = 3'h3; // Jump relative to data pointer
  localparam logic [2:0] MSD_CYC_FOUR = 3'h4; // Extended and code moves

  // ----------------------------------------------------------------
  // Addressing modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    MSD_M_REG = 12'h001, // Working register of active bank
    MSD_M_DIRECT = 12'h002, // Direct byte address
    MSD_M_INDIRECT = 12'h004, // Through pointer register
    MSD_M_IMMED = 12'h008, // Literal from program memory
    MSD_M_BIT = 12'h010, // Single bit address
    MSD_M_XIND = 12'h020, // Extended RAM through pointer register
    MSD_M_XDIR = 12'h040, // Extended RAM through data pointer
    MSD_M_CODE_DP = 12'h080, // Code byte at data pointer plus A
    MSD_M_CODE_PC = 12'h100, // Code byte at program counter plus A
    MSD_M_JMP = 12'h200, // Jump target data pointer plus A
    MSD_M_PUSH = 12'h400, // Push onto extended RAM stack
    MSD_M_POP = 12'h800 // Pop from extended RAM stack
  } msd_mode_t;

  // Controller states
  typedef enum logic [1:0] {
    MSD_S_IDLE = 2'h1,
    MSD_S_BUSY = 2'h2
  } msd_state_t;

endpackage

// *** src/msd_mem_if.sv ***
// Port bundle between the decoder and its extended RAM.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none

interface msd_mem_if;
  logic [7:0] addr; // Byte address
  logic we; // Write strobe
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Read data, same cycle

  modport owner (input addr, input we, input wdata, output rdata);
  modport user (output addr, output we, output wdata, input rdata);
endinterface

`default_nettype wire

// *** src/msd_extended_internal_ram.sv ***
// Extended internal RAM array with asynchronous read and clocked write.
// Assumes the decoder owns the address and strobe on the core clock.
`timescale 1ns/10ps
`default_nettype none

module msd_extended_internal_ram #(
  parameter int DEPTH = 256
) (
  input wire logic i_clk,
  msd_mem_if.owner mem
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] store [0:DEPTH-1]; // Extended RAM bytes

  // Address must span exactly the array
  if (DEPTH != 256)
  begin : g_bad_depth
    $error("msd_extended_internal_ram depth must be 256");
  end

  // Read path
  assign mem.rdata = store[mem.addr];

  // Write path
  always_ff @(posedge i_clk)
  begin
    if (mem.we)
    begin
      store[mem.addr] <= mem.wdata;
    end
  end

  // Written byte reads back next cycle
  property p_extended_internal_ram_write_lands;
    @(posedge i_clk) mem.we |=> store[$past(mem.addr)] == $past(mem.wdata);
  endproperty
  a_extended_internal_ram_write_lands: assert property (p_extended_internal_ram_write_lands)
    else $error("extended RAM write did not land");

endmodule

`default_nettype wire

// *** src/msd_core_memory_space_decoder.sv ***
// Memory space decoder: routes core accesses to RAM, SFRs, extended RAM, code.
// Assumes the core holds request fields while O_REQ_READY is low.
//
// What this block does
// - 256 bytes internal RAM, 0x00 to 0xFF
// - Low 128 bytes: direct and indirect alike
// - Indirect upper addresses hit upper RAM
// - Direct upper addresses hit SPECIAL_FUNCTION_REGISTER_SPACE space
// - Bit addresses below 0x80 map onto bytes 0x20-0x2F
// - Bits usable by Boolean and branch ops
// - SFRs reachable only by direct and bit addressing
// - Only designated SFRs allow bit access
// - Separate 256-byte extended RAM, extended moves
// - Pointer register addresses extended RAM
// - Data pointer addresses extended RAM
// - Code reads from 16 kB flash
// - Immediate operands fetched, take more cycles
// - Register moves finish in one cycle
// - Indirect uses pointer register contents
// - Four eight-byte banks in first 32 bytes
// - Status word bits choose active bank
// - Stack lives in extended RAM
`timescale 1ns/10ps
`default_nettype none

module msd_core_memory_space_decoder #(
  parameter int CODE_AW = 14, // Flash address width, 16 kB
  parameter logic [15:0] BIT_SFR_ROWS = 16'hFFFF // Bit-addressable SPECIAL_FUNCTION_REGISTER_SPACE rows
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_REQ_VALID,
  output logic O_REQ_READY,
  input wire logic [11:0] I_MODE,
  input wire logic I_WRITE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WBIT,
  input wire logic [7:0] I_ACC,
  input wire logic [15:0] I_PC,
  output logic O_DONE,
  output logic [7:0] O_RDATA,
  output logic O_RBIT,
  output logic [15:0] O_TARGET,
  output logic O_ERR,
  output logic [1:0] O_BANK,
  output logic [7:0] O_SFR_ADDR,
  output logic O_SFR_RE,
  output logic O_SFR_WE,
  output logic [7:0] O_SFR_WDATA,
  input wire logic [7:0] I_SFR_RDATA,
  output logic [CODE_AW-1:0] O_CODE_ADDR,
  input wire logic [7:0] I_CODE_DATA
);

  if (CODE_AW < 8 || CODE_AW > 16)
  begin : g_bad_aw
    $error("CODE_AW must lie in 8..16");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Core SFRs held inside this block
  function automatic logic is_core_sfr(input logic [7:0] a);
    return a == msd_pkg::MSD_SFR_SP || a == msd_pkg::MSD_SFR_DPL ||
           a == msd_pkg::MSD_SFR_DPH || a == msd_pkg::MSD_SFR_PSW;
  endfunction

  // Cycles minus one for a mode
  function automatic logic [1:0] wait_for(input msd_pkg::msd_mode_t m);
    unique case (m)
      msd_pkg::MSD_M_REG: return 2'(msd_pkg::MSD_CYC_REG - 2'h1);
      msd_pkg::MSD_M_XIND, msd_pkg::MSD_M_XDIR,
      msd_pkg::MSD_M_CODE_DP, msd_pkg::MSD_M_CODE_PC:
        return 2'(msd_pkg::MSD_CYC_FOUR - 3'h1);
      msd_pkg::MSD_M_JMP: return 2'(msd_pkg::MSD_CYC_JMP - 3'h1);
      default: return 2'(msd_pkg::MSD_CYC_TWO - 2'h1);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Storage and sub-blocks
  // ----------------------------------------------------------------
  logic [7:0] iram [0:255]; // Internal RAM
  msd_mem_if xbus (); // Extended RAM port

  msd_extended_internal_ram #(.DEPTH(256)) u_extended_internal_ram (
    .i_clk(I_CORE_CLK),
    .mem(xbus.owner)
  );

  // ----------------------------------------------------------------
  // Control group: accept, count, latch request
  // ----------------------------------------------------------------
  msd_pkg::msd_state_t state, next_state; // Idle or busy
  logic [1:0] cnt, next_cnt; // Cycles left
  msd_pkg::msd_mode_t r_mode, next_r_mode; // Latched mode
  logic r_write, next_r_write; // Latched direction
  logic [7:0] r_addr, next_r_addr; // Latched address field
  logic [7:0] r_wdata, next_r_wdata; // Latched write byte
  logic r_wbit, next_r_wbit; // Latched write bit
  logic [7:0] r_acc, next_r_acc; // Latched accumulator
  logic r_bad, next_r_bad; // Illegal mode code
  logic [CODE_AW-1:0] next_code_addr; // Flash address to present
  logic done_now; // Final cycle of an access
  logic take; // Request accepted
  logic [7:0] sp, dpl, dph, program_status_word; // Core SFRs
  logic [15:0] data_pointer_pair; // Data pointer pair

  assign data_pointer_pair = {dph, dpl};
  assign done_now = (state == msd_pkg::MSD_S_BUSY) && (cnt == 2'h0);
  assign O_REQ_READY = (state == msd_pkg::MSD_S_IDLE) || done_now;
  assign take = I_REQ_VALID && O_REQ_READY;
  assign O_DONE = done_now;

  // Next control values
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_r_mode = r_mode;
    next_r_write = r_write;
    next_r_addr = r_addr;
    next_r_wdata = r_wdata;
    next_r_wbit = r_wbit;
    next_r_acc = r_acc;
    next_r_bad = r_bad;
    next_code_addr = O_CODE_ADDR;
    if (take)
    begin
      next_state = msd_pkg::MSD_S_BUSY;
      next_r_mode = msd_pkg::msd_mode_t'(I_MODE);
      next_r_bad = !$onehot(I_MODE);
      next_cnt = wait_for(msd_pkg::msd_mode_t'(I_MODE));
      next_r_write = I_WRITE;
      next_r_addr = I_ADDR;
      next_r_wdata = I_WDATA;
      next_r_wbit = I_WBIT;
      next_r_acc = I_ACC;
      // Flash address held for the whole access
      if (I_MODE == msd_pkg::MSD_M_IMMED)
      begin
        next_code_addr = I_PC[CODE_AW-1:0];
      end
      else if (I_MODE == msd_pkg::MSD_M_CODE_DP)
      begin
        next_code_addr = CODE_AW'(data_pointer_pair + {8'h00, I_ACC});
      end
      else if (I_MODE == msd_pkg::MSD_M_CODE_PC)
      begin
        next_code_addr = CODE_AW'(I_PC + {8'h00, I_ACC});
      end
    end
    else if (done_now)
    begin
      next_state = msd_pkg::MSD_S_IDLE;
    end
    else if (state == msd_pkg::MSD_S_BUSY)
    begin
      next_cnt = cnt - 2'h1;
    end
  end

  // Control registers
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      state <= msd_pkg::MSD_S_IDLE;
      cnt <= 2'h0;
      r_mode <= msd_pkg::MSD_M_REG;
      r_write <= 1'b0;
      r_addr <= 8'h00;
      r_wdata <= 8'h00;
      r_wbit <= 1'b0;
      r_acc <= 8'h00;
      r_bad <= 1'b0;
      O_CODE_ADDR <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      r_mode <= next_r_mode;
      r_write <= next_r_write;
      r_addr <= next_r_addr;
      r_wdata <= next_r_wdata;
      r_wbit <= next_r_wbit;
      r_acc <= next_r_acc;
      r_bad <= next_r_bad;
      O_CODE_ADDR <= next_code_addr;
    end
  end

  // ----------------------------------------------------------------
  // Datapath group: decode space, move bytes, update SFRs
  // ----------------------------------------------------------------
  logic [7:0] bank_base; // First byte of active bank
  logic [7:0] ptr_val; // Contents of pointer register
  logic [7:0] bit_byte; // Byte holding an addressed bit
  logic sel_iram, sel_sfr, sel_x; // Space chosen
  logic [7:0] a_byte; // Byte address in that space
  logic [7:0] rd_byte, wr_byte; // Read value, value to store
  logic bit_ok; // Bit access allowed
  logic iram_we; // Internal RAM write strobe
  logic [7:0] next_sp, next_dpl, next_dph, next_psw;
  logic [7:0] next_rdata;
  logic next_rbit, next_err;
  logic [15:0] next_target;

  // Bank base from the status word
  assign bank_base = {3'h0, program_status_word[msd_pkg::MSD_BANK_MSB:msd_pkg::MSD_BANK_LSB], 3'h0};
  assign O_BANK = program_status_word[msd_pkg::MSD_BANK_MSB:msd_pkg::MSD_BANK_LSB];
  // Pointer register read from the active bank
  assign ptr_val = iram[bank_base | {7'h00, r_addr[0]}];
  // Bit to byte mapping
  assign bit_byte = r_addr[7] ? {r_addr[7:3], 3'h0} : msd_pkg::MSD_BIT_BASE + {4'h0, r_addr[6:3]};

  // Space decode and byte movement
  always_comb
  begin
    sel_iram = 1'b0;
    sel_sfr = 1'b0;
    sel_x = 1'b0;
    a_byte = 8'h00;
    bit_ok = 1'b1;
    unique case (r_mode)
      msd_pkg::MSD_M_REG:
      begin
        sel_iram = 1'b1;
        a_byte = bank_base | {5'h00, r_addr[2:0]};
      end
      msd_pkg::MSD_M_DIRECT:
      begin
        // Upper half goes to SFRs, lower to RAM
        sel_sfr = r_addr[7];
        sel_iram = !r_addr[7];
        a_byte = r_addr;
      end
      msd_pkg::MSD_M_INDIRECT:
      begin
        sel_iram = 1'b1; // Never an SPECIAL_FUNCTION_REGISTER_SPACE
        a_byte = ptr_val;
      end
      msd_pkg::MSD_M_BIT:
      begin
        sel_sfr = r_addr[7];
        sel_iram = !r_addr[7];
        a_byte = bit_byte;
        bit_ok = !r_addr[7] || BIT_SFR_ROWS[r_addr[6:3]];
      end
      msd_pkg::MSD_M_XIND:
      begin
        sel_x = 1'b1;
        a_byte = ptr_val;
      end
      msd_pkg::MSD_M_XDIR:
      begin
        sel_x = 1'b1;
        a_byte = dpl; // Low byte only
      end
      msd_pkg::MSD_M_PUSH:
      begin
        sel_x = 1'b1;
        a_byte = sp + 8'h01;
      end
      msd_pkg::MSD_M_POP:
      begin
        sel_x = 1'b1;
        a_byte = sp;
      end
      default:
      begin
        a_byte = 8'h00; // Code, jump or illegal: no data space
      end
    endcase
    // Read the selected byte
    if (sel_iram)
      rd_byte = iram[a_byte];
    else if (sel_x)
      rd_byte = xbus.rdata;
    else if (a_byte == msd_pkg::MSD_SFR_SP)
      rd_byte = sp;
    else if (a_byte == msd_pkg::MSD_SFR_DPL)
      rd_byte = dpl;
    else if (a_byte == msd_pkg::MSD_SFR_DPH)
      rd_byte = dph;
    else if (a_byte == msd_pkg::MSD_SFR_PSW)
      rd_byte = program_status_word;
    else
      rd_byte = I_SFR_RDATA;
    // Bit writes merge into the byte
    wr_byte = r_wdata;
    if (r_mode == msd_pkg::MSD_M_BIT)
    begin
      wr_byte = rd_byte;
      wr_byte[r_addr[2:0]] = r_wbit;
    end
  end

  // Strobes and register updates at the final cycle
  always_comb
  begin
    next_sp = sp;
    next_dpl = dpl;
    next_dph = dph;
    next_psw = program_status_word;
    next_rdata = O_RDATA;
    next_rbit = O_RBIT;
    next_target = O_TARGET;
    next_err = O_ERR;
    iram_we = 1'b0;
    xbus.we = 1'b0;
    O_SFR_RE = 1'b0;
    O_SFR_WE = 1'b0;
    if (done_now)
    begin
      next_err = r_bad || !bit_ok;
      next_rdata = rd_byte;
      next_rbit = rd_byte[r_addr[2:0]];
      if (r_mode == msd_pkg::MSD_M_IMMED || r_mode == msd_pkg::MSD_M_CODE_DP ||
          r_mode == msd_pkg::MSD_M_CODE_PC)
        next_rdata = I_CODE_DATA;
      if (r_mode == msd_pkg::MSD_M_JMP)
        next_target = data_pointer_pair + {8'h00, r_acc};
      if (r_mode == msd_pkg::MSD_M_PUSH)
        next_sp = sp + 8'h01;
      if (r_mode == msd_pkg::MSD_M_POP)
        next_sp = sp - 8'h01;
      O_SFR_RE = sel_sfr && !is_core_sfr(a_byte) && (!r_write || r_mode == msd_pkg::MSD_M_BIT);
      // Pop never writes, whatever the direction bit says
      if (!r_bad && bit_ok && ((r_write && r_mode != msd_pkg::MSD_M_POP) ||
          r_mode == msd_pkg::MSD_M_PUSH))
      begin
        iram_we = sel_iram;
        xbus.we = sel_x;
        O_SFR_WE = sel_sfr && !is_core_sfr(a_byte);
        if (sel_sfr && a_byte == msd_pkg::MSD_SFR_SP)
          next_sp = wr_byte;
        if (sel_sfr && a_byte == msd_pkg::MSD_SFR_DPL)
          next_dpl = wr_byte;
        if (sel_sfr && a_byte == msd_pkg::MSD_SFR_DPH)
          next_dph = wr_byte;
        if (sel_sfr && a_byte == msd_pkg::MSD_SFR_PSW)
          next_psw = wr_byte;
      end
    end
  end

  assign xbus.addr = a_byte;
  assign xbus.wdata = wr_byte;
  assign O_SFR_ADDR = a_byte;
  assign O_SFR_WDATA = wr_byte;

  // Datapath registers
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      sp <= msd_pkg::MSD_SP_RST;
      dpl <= msd_pkg::MSD_DP_RST;
      dph <= msd_pkg::MSD_DP_RST;
      program_status_word <= msd_pkg::MSD_PSW_RST;
      O_RDATA <= 8'h00;
      O_RBIT <= 1'b0;
      O_TARGET <= 16'h0000;
      O_ERR <= 1'b0;
    end
    else
    begin
      sp <= next_sp;
      dpl <= next_dpl;
      dph <= next_dph;
      program_status_word <= next_psw;
      O_RDATA <= next_rdata;
      O_RBIT <= next_rbit;
      O_TARGET <= next_target;
      O_ERR <= next_err;
    end
  end

  // Internal RAM write port
  always_ff @(posedge I_CORE_CLK)
  begin
    if (iram_we)
    begin
      iram[a_byte] <= wr_byte;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_two;
    !O_DONE ##1 O_DONE;
  endsequence
  sequence s_three;
    !O_DONE[*2] ##1 O_DONE;
  endsequence
  sequence s_four;
    !O_DONE[*3] ##1 O_DONE;
  endsequence

  property p_reg_one;
    take && I_MODE == msd_pkg::MSD_M_REG |=> O_DONE;
  endproperty
  a_reg_one: assert property (p_reg_one)
    else $error("register move not done in one cycle");

  property p_immed_two;
    take && I_MODE == msd_pkg::MSD_M_IMMED |=> s_two;
  endproperty
  a_immed_two: assert property (p_immed_two)
    else $error("immediate fetch timing wrong");

  property p_ext_four;
    take && (I_MODE == msd_pkg::MSD_M_XIND || I_MODE == msd_pkg::MSD_M_XDIR ||
             I_MODE == msd_pkg::MSD_M_CODE_DP) |=> s_four;
  endproperty
  a_ext_four: assert property (p_ext_four)
    else $error("extended or code move not four cycles");

  property p_jmp_three;
    take && I_MODE == msd_pkg::MSD_M_JMP |=> s_three;
  endproperty
  a_jmp_three: assert property (p_jmp_three)
    else $error("jump not three cycles");

  property p_indirect_ram;
    done_now && r_mode == msd_pkg::MSD_M_INDIRECT |-> !O_SFR_RE && !O_SFR_WE && sel_iram;
  endproperty
  a_indirect_ram: assert property (p_indirect_ram)
    else $error("indirect access reached SPECIAL_FUNCTION_REGISTER_SPACE space");

  property p_direct_sfr;
    done_now && r_mode == msd_pkg::MSD_M_DIRECT && r_addr[7] |-> !iram_we && sel_sfr;
  endproperty
  a_direct_sfr: assert property (p_direct_sfr)
    else $error("direct upper access went to RAM");

  property p_bit_map;
    done_now && r_mode == msd_pkg::MSD_M_BIT && !r_addr[7] |->
      a_byte == msd_pkg::MSD_BIT_BASE + {4'h0, r_addr[6:3]};
  endproperty
  a_bit_map: assert property (p_bit_map)
    else $error("bit address mapped to wrong byte");

  property p_bank_range;
    done_now && r_mode == msd_pkg::MSD_M_REG |->
      a_byte <= msd_pkg::MSD_BANK_TOP && a_byte[4:3] == O_BANK;
  endproperty
  a_bank_range: assert property (p_bank_range)
    else $error("register outside active bank");

  property p_push_sp;
    done_now && r_mode == msd_pkg::MSD_M_PUSH |-> xbus.we ##1 sp == $past(sp) + 8'h01;
  endproperty
  a_push_sp: assert property (p_push_sp)
    else $error("push did not write stack and advance pointer");

  property p_xdir_low;
    done_now && r_mode == msd_pkg::MSD_M_XDIR |-> xbus.addr == dpl;
  endproperty
  a_xdir_low: assert property (p_xdir_low)
    else $error("extended direct not at data pointer low byte");

endmodule

`default_nettype wire

// *** verif/msd_far_model.sv ***
// Far side model: peripheral register file of the upper half and the flash.
// Assumes the decoder strobes registers only in its done cycle.
`timescale 1ns/10ps
`default_nettype none

module msd_far_model (
  input wire logic i_clk,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_re,
  input wire logic i_sfr_we,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [13:0] i_code_addr,
  output logic [7:0] o_code_data
);
  // --------------------------------------------------------------
  // Register file, known start pattern
  // --------------------------------------------------------------
  logic [7:0] special_function_register_space [128]; // Peripheral registers 0x80-0xFF
  initial
  begin
    for (int i = 0; i < 128; i++)
      special_function_register_space[i] = 8'(i + 128) ^ 8'hC3;
  end
  // Byte write on the strobe edge
  always @(posedge i_clk)
  begin
    if (i_sfr_we)
      special_function_register_space[i_sfr_addr[6:0]] <= i_sfr_wdata;
  end
  // Unselected bus shows inverted data so stale reads are caught
  assign o_sfr_rdata = i_sfr_re ? special_function_register_space[i_sfr_addr[6:0]] : ~special_function_register_space[i_sfr_addr[6:0]];
  // Flash content follows its 14-bit address
  assign o_code_data = i_code_addr[7:0] ^ {2'h0, i_code_addr[13:8]};
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the memory space decoder, table driven.
// Assumes the far side model and a 10 MHz core clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  typedef struct {logic [11:0] m; logic w; logic [7:0] a; logic [7:0] d; logic b;
    logic [7:0] c; logic [15:0] p; int n; int k; logic [15:0] x; logic e; logic s;} msd_row_t;
  localparam logic [11:0] rg = 12'h001, di = 12'h002, in = 12'h004, im = 12'h008;
  localparam logic [11:0] bi = 12'h010, xi = 12'h020, xd = 12'h040, cd = 12'h080;
  localparam logic [11:0] cp = 12'h100, jm = 12'h200, pu = 12'h400, po = 12'h800;
  logic clk = 1'h0, rst = 1'h1, vld = 1'h0, wr = 1'h0, wb = 1'h0, rdy, done, rb, err;
  logic sre, swe;
  logic [11:0] mode = 12'h001;
  logic [7:0] addr = 8'h00, wd = 8'h00, acc = 8'h00, rd, sa, swd, srd, cdat;
  logic [15:0] pc = 16'h0000, tgt;
  logic [1:0] bank;
  logic [13:0] ca;
  int miscompares = 0, n_compared = 0, cyc = 0;
  // --------------------------------------------------------------
  // Cases: mode,wr,addr,wdata,wbit,acc,pc,cycles,kind,expect,err,strobe
  // --------------------------------------------------------------
  msd_row_t rows [40] = '{
    '{di,1,8'h30,8'hA5,0,0,0,2,0,0,0,0}, '{rg,1,8'h00,8'h30,0,0,0,1,0,0,0,0},
    '{in,0,8'h00,0,0,0,0,2,1,8'hA5,0,0}, '{rg,1,8'h00,8'h90,0,0,0,1,0,0,0,0},
    '{in,1,8'h00,8'h5A,0,0,0,2,0,0,0,0}, '{di,0,8'h90,0,0,0,0,2,1,8'h53,0,1},
    '{in,0,8'h00,0,0,0,0,2,1,8'h5A,0,0}, '{di,1,8'h90,8'h11,0,0,0,2,0,0,0,1},
    '{di,0,8'h90,0,0,0,0,2,1,8'h11,0,1}, '{bi,1,8'h91,0,1,0,0,2,0,0,0,1},
    '{di,0,8'h90,0,0,0,0,2,1,8'h13,0,1}, '{bi,1,8'h88,0,1,0,0,2,0,0,1,0},
    '{di,0,8'h88,0,0,0,0,2,1,8'h4B,0,1}, '{di,1,8'h21,8'h00,0,0,0,2,0,0,0,0},
    '{bi,1,8'h09,0,1,0,0,2,0,0,0,0}, '{di,0,8'h21,0,0,0,0,2,1,8'h02,0,0},
    '{bi,0,8'h09,0,0,0,0,2,2,1,0,0}, '{bi,0,8'h0F,0,0,0,0,2,2,0,0,0},
    '{di,1,8'h2F,8'h00,0,0,0,2,0,0,0,0}, '{bi,1,8'h7F,0,1,0,0,2,0,0,0,0},
    '{di,0,8'h2F,0,0,0,0,2,1,8'h80,0,0}, '{rg,1,8'h00,8'h44,0,0,0,1,0,0,0,0},
    '{xi,1,8'h00,8'h77,0,0,0,4,0,0,0,0}, '{di,1,8'h82,8'h44,0,0,0,2,0,0,0,0},
    '{di,1,8'h83,8'h12,0,0,0,2,0,0,0,0}, '{xd,0,8'h00,0,0,0,0,4,1,8'h77,0,0},
    '{cd,0,0,0,0,8'h05,0,4,1,8'h5B,0,0}, '{cp,0,0,0,0,8'h20,16'h3FF0,4,1,8'h10,0,0},
    '{jm,0,0,0,0,8'h05,0,3,3,16'h1249,0,0}, '{im,0,0,0,0,0,16'h0100,2,1,8'h01,0,0},
    '{di,1,8'hD0,8'h18,0,0,0,2,4,3,0,0}, '{rg,1,8'h00,8'hAB,0,0,0,1,0,0,0,0},
    '{di,0,8'h18,0,0,0,0,2,1,8'hAB,0,0}, '{di,1,8'h81,8'h10,0,0,0,2,0,0,0,0},
    '{pu,1,8'h00,8'h3C,0,0,0,2,0,0,0,0}, '{di,1,8'h82,8'h11,0,0,0,2,0,0,0,0},
    '{xd,0,8'h00,0,0,0,0,4,1,8'h3C,0,0}, '{po,0,8'h00,0,0,0,0,2,1,8'h3C,0,0},
    '{12'h003,0,0,0,0,0,0,2,0,0,1,0}, '{di,0,8'h30,0,0,0,0,2,1,8'hA5,0,0}};

  msd_core_memory_space_decoder #(.BIT_SFR_ROWS(16'h0004)) msd_core_memory_space_decoder_inst (
    .I_CORE_CLK(clk), .I_RST(rst), .I_REQ_VALID(vld), .O_REQ_READY(rdy), .I_MODE(mode),
    .I_WRITE(wr), .I_ADDR(addr), .I_WDATA(wd), .I_WBIT(wb), .I_ACC(acc), .I_PC(pc),
    .O_DONE(done), .O_RDATA(rd), .O_RBIT(rb), .O_TARGET(tgt), .O_ERR(err), .O_BANK(bank),
    .O_SFR_ADDR(sa), .O_SFR_RE(sre), .O_SFR_WE(swe), .O_SFR_WDATA(swd),
    .I_SFR_RDATA(srd), .O_CODE_ADDR(ca), .I_CODE_DATA(cdat));
  msd_far_model msd_far_model_inst (.i_clk(clk), .i_sfr_addr(sa), .i_sfr_re(sre),
    .i_sfr_we(swe), .i_sfr_wdata(swd), .o_sfr_rdata(srd), .i_code_addr(ca),
    .o_code_data(cdat));

  // --------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // Value compare, four-state exact
  task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Latency compare in cycles
  task automatic cmp_cyc(input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      miscompares++;
      $display("wrong value cycles expected %0d seen %0d", e, g);
    end
  endtask
  // One access: drive at falling edge, wait for done, check results
  task automatic do_row(input msd_row_t r);
    int n;
    logic st;
    @(negedge clk);
    vld = 1'h1;
    mode = r.m;
    wr = r.w;
    addr = r.a;
    wd = r.d;
    wb = r.b;
    acc = r.c;
    pc = r.p;
    cmp_val("ready", 16'h1, {15'h0, rdy});
    @(negedge clk);
    vld = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    st = r.w ? swe : sre;
    @(negedge clk);
    cmp_cyc(r.n, n);
    cmp_val("strobe", {15'h0, r.s}, {15'h0, st});
    cmp_val("err", {15'h0, r.e}, {15'h0, err});
    if (r.k == 1) cmp_val("rdata", r.x, {8'h00, rd});
    if (r.k == 2) cmp_val("rbit", r.x, {15'h0, rb});
    if (r.k == 3) cmp_val("target", r.x, tgt);
    if (r.k == 4) cmp_val("bank", r.x, {14'h0, bank});
  endtask
  // Closing report
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence: reset, table, reset in mid-run
  // --------------------------------------------------------------
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    foreach (rows[i])
      do_row(rows[i]);
    rst = 1'h1;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    cmp_val("bank", 16'h0, {14'h0, bank});
    cmp_val("ready", 16'h1, {15'h0, rdy});
    do_row(rows[39]);
    // Back to back: second request waits out the busy cycle
    @(negedge clk);
    vld = 1'h1;
    mode = di;
    wr = 1'h1;
    addr = 8'h31;
    wd = 8'h66;
    @(negedge clk);
    wr = 1'h0;
    cmp_val("ready", 16'h0, {15'h0, rdy});
    @(negedge clk);
    cmp_val("ready", 16'h1, {15'h0, rdy});
    @(negedge clk);
    vld = 1'h0;
    @(negedge clk);
    cmp_val("done", 16'h1, {15'h0, done});
    @(negedge clk);
    cmp_val("rdata", 16'h0066, {8'h00, rd});
    give_verdict();
  end
endmodule

`default_nettype wire
